/* pkg/afe_adc_pkg.sv */
// constants for the gas-sensor front-end offset trim and converter control block
// ****************************************************************************
// Behaviour
// - mode bit one selects offset calibration mode
// - converter yields a twelve bit result
// - source and channel fields jointly choose input
// - internal sources share the single converter
// - alignment bit selects left or right result layout
// - unused result bits read as zero
// - disabled converter keeps the stored result
// - result registers are read only
// - exactly one selected signal converted at once
// - status bit reads zero outside calibration mode
// - start high then low launches a conversion
// - busy set on launch, cleared on completion
// ****************************************************************************
package afe_adc_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_RES_LOW   = 8'h00;
   localparam logic [7:0] OFF_RES_HIGH  = 8'h04;
   localparam logic [7:0] OFF_CTRL_START = 8'h08;
   localparam logic [7:0] OFF_CTRL_SRC  = 8'h0c;
   localparam logic [7:0] OFF_CTRL_MODE = 8'h10;
   localparam logic [7:0] OFF_BANDGAP   = 8'h14;
   localparam logic [7:0] OFF_AMP_CTRL  = 8'h18;
   localparam logic [7:0] OFF_OFFSET_CAL = 8'h1c;
   // field positions, start/channel register
   localparam int START_BIT = 7;
   localparam int BUSY_BIT  = 6;
   localparam int EN_BIT    = 5;
   localparam int ALIGN_BIT = 4;
   // source/clock register
   localparam int SRC_MSB = 7;
   localparam int SRC_LSB = 5;
   localparam int REF_MSB = 4;
   localparam int REF_LSB = 3;
   // mode/temp register
   localparam int LOWCUR_BIT = 7;
   localparam int FIXED1_BIT = 1;
   // amplifier control register
   localparam int AMP_EN_BIT  = 6;
   localparam int AMP_STS_BIT = 5;
   // offset calibration register
   localparam int CALMODE_BIT = 7;
   localparam int CALREF_BIT  = 6;
   // reset values
   localparam logic [5:0] TRIM_RESET   = 6'h20;
   localparam logic       FIXED1_RESET = 1'b1;
   // source select codes
   localparam logic [2:0] SRC_BANDGAP  = 3'h1;
   localparam logic [2:0] SRC_TEMP     = 3'h2;
   localparam logic [2:0] SRC_AMP_OUT  = 3'h3;
   localparam logic [2:0] SRC_AMP_POS  = 3'h4;
   localparam logic [2:0] SRC_FORBID   = 3'h7;
   // analog mux selection codes driven to the analog side
   localparam logic [3:0] SEL_BANDGAP  = 4'h8;
   localparam logic [3:0] SEL_TEMP     = 4'h9;
   localparam logic [3:0] SEL_AMP_OUT  = 4'ha;
   localparam logic [3:0] SEL_AMP_POS  = 4'hb;
   localparam logic [3:0] SEL_NONE     = 4'hf;
   localparam int RES_W = 12;
   typedef enum logic [0:0] {
      CONV_IDLE = 1'b0,
      CONV_BUSY = 1'b1
   } conv_state_t;
endpackage

/* design/sync3.sv */
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // per bit: stage one feeds only stage two; output moves when two and three agree
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            s1_q[b] <= 1'b0;
            s2_q[b] <= 1'b0;
            s3_q[b] <= 1'b0;
            q_o[b]  <= 1'b0;
         end else begin
            s1_q[b] <= d_i[b];
            s2_q[b] <= s1_q[b];
            s3_q[b] <= s2_q[b];
            if (s2_q[b] == s3_q[b]) begin
               q_o[b] <= s3_q[b];
            end
         end
      end
   end
endmodule

/* design/result_format.sv */
// places the twelve-bit result into the high and low byte views
`timescale 1ns/1ps
module result_format (
   input  wire logic        align_i,
   input  wire logic [11:0] result_i,
   output logic      [7:0]  high_o,
   output logic      [7:0]  low_o
);
   logic [7:0] left_high;
   logic [7:0] left_low;
   logic [7:0] right_high;
   logic [7:0] right_low;

   // left layout pads the low nibble, right layout pads the high nibble with zero
   assign left_high  = result_i[11:4];
   assign left_low   = {result_i[3:0], 4'h0};
   assign right_high = {4'h0, result_i[11:8]};
   assign right_low  = result_i[7:0];
   assign high_o     = align_i ? right_high : left_high;
   assign low_o      = align_i ? right_low : left_low;
endmodule

/* design/afe_adc_ctrl.sv */
// register file, offset trim control and conversion sequencer for the sensor front end
`timescale 1ns/1ps
module afe_adc_ctrl (
   input  wire logic                           CORE_CLK_I,
   input  wire logic                           RST_I,
   // apb slave
   input  wire logic                           PSEL_I,
   input  wire logic                           PENABLE_I,
   input  wire logic                           PWRITE_I,
   input  wire logic [7:0]                     PADDR_I,
   input  wire logic [31:0]                    PWDATA_I,
   output logic      [31:0]                    PRDATA_O,
   output logic                                PREADY_O,
   output logic                                PSLVERR_O,
   // amplifier side
   input  wire logic                           AMP_STATUS_I,
   output logic                                AMP_ENABLE_O,
   output logic      [1:0]                     AMP_BW_O,
   output logic                                OFFSET_CAL_MODE_O,
   output logic                                OFFSET_REF_SEL_O,
   output logic      [5:0]                     OFFSET_TRIM_O,
   // converter side
   input  wire logic                           CONV_DONE_I,
   input  wire logic [afe_adc_pkg::RES_W-1:0]  CONV_DATA_I,
   output logic                                CONV_ENABLE_O,
   output logic                                CONV_START_O,
   output logic      [3:0]                     ANALOG_SEL_O,
   output logic      [1:0]                     REF_SEL_O,
   output logic      [2:0]                     CONV_CLK_SEL_O,
   output logic                                LOW_CURRENT_O,
   output logic                                TEMP_SENSOR_EN_O,
   output logic                                BANDGAP_EN_O
);
   import afe_adc_pkg::*;

   // ************************************************************************
   // register storage
   // ************************************************************************
   logic              start_q;
   logic              conv_en_q;
   logic              align_q;
   logic [3:0]        chan_q;
   logic [2:0]        src_q;
   logic [1:0]        ref_q;
   logic [2:0]        clk_sel_q;
   logic              lowcur_q;
   logic              fixed1_q;
   logic              temp_sensor_enable_q;
   logic              bg_en_q;
   logic              amp_en_q;
   logic [1:0]        amp_bw_q;
   logic              cal_mode_q;
   logic              cal_ref_q;
   logic [5:0]        trim_q;
   logic [RES_W-1:0]  result_q;
   logic [31:0]       prdata_q;
   logic              start_pulse_q;
   logic              done_prev_q;
   conv_state_t       state_q;
   conv_state_t       state_d;

   logic              amp_sts_s;
   logic              done_s;
   logic [RES_W-1:0]  data_s;
   logic [7:0]        fmt_high;
   logic [7:0]        fmt_low;

   // ************************************************************************
   // apb decode
   // ************************************************************************
   logic        setup_ph;
   logic        access_ph;
   logic        wr_en;
   logic        hit_low;
   logic        hit_high;
   logic        hit_start;
   logic        hit_src;
   logic        hit_mode;
   logic        hit_bg;
   logic        hit_amp;
   logic        hit_cal;
   logic        mapped;
   logic [7:0]  wb;
   logic [7:0]  rd_byte;
   logic        amp_sts_rd;
   logic        launch;
   logic        done_rise;
   logic        busy;

   // zero-wait slave: read data is fetched in setup so it comes from a flop
   assign setup_ph  = PSEL_I && !PENABLE_I;
   assign access_ph = PSEL_I && PENABLE_I;
   assign wr_en     = access_ph && PWRITE_I;
   assign wb        = PWDATA_I[7:0];
   assign hit_low   = (PADDR_I == OFF_RES_LOW);
   assign hit_high  = (PADDR_I == OFF_RES_HIGH);
   assign hit_start = (PADDR_I == OFF_CTRL_START);
   assign hit_src   = (PADDR_I == OFF_CTRL_SRC);
   assign hit_mode  = (PADDR_I == OFF_CTRL_MODE);
   assign hit_bg    = (PADDR_I == OFF_BANDGAP);
   assign hit_amp   = (PADDR_I == OFF_AMP_CTRL);
   assign hit_cal   = (PADDR_I == OFF_OFFSET_CAL);
   assign mapped    = hit_low || hit_high || hit_start || hit_src || hit_mode
                      || hit_bg || hit_amp || hit_cal;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = access_ph && !mapped;

   // status only reflects the amplifier while calibrating
   assign amp_sts_rd = cal_mode_q && amp_sts_s;
   assign busy       = (state_q == CONV_BUSY);

   // read mux; unused upper bits read zero
   assign rd_byte = hit_low   ? fmt_low :
                    hit_high  ? fmt_high :
                    hit_start ? {start_q, busy, conv_en_q, align_q, chan_q} :
                    hit_src   ? {src_q, ref_q, clk_sel_q} :
                    hit_mode  ? {lowcur_q, 5'h00, fixed1_q, temp_sensor_enable_q} :
                    hit_bg    ? {7'h00, bg_en_q} :
                    hit_amp   ? {1'b0, amp_en_q, amp_sts_rd, 3'h0, amp_bw_q} :
                    hit_cal   ? {cal_mode_q, cal_ref_q, trim_q} :
                    8'h00;

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end
   assign PRDATA_O = prdata_q;

   // ************************************************************************
   // input synchronisers
   // ************************************************************************
   sync3 #(.W(1)) u_sync_sts (
      .clk_i (CORE_CLK_I),
      .rst_i (RST_I),
      .d_i   (AMP_STATUS_I),
      .q_o   (amp_sts_s)
   );

   sync3 #(.W(1)) u_sync_done (
      .clk_i (CORE_CLK_I),
      .rst_i (RST_I),
      .d_i   (CONV_DONE_I),
      .q_o   (done_s)
   );

   // data settles before done rises, so both arrive filtered together
   sync3 #(.W(RES_W)) u_sync_data (
      .clk_i (CORE_CLK_I),
      .rst_i (RST_I),
      .d_i   (CONV_DATA_I),
      .q_o   (data_s)
   );

   // ************************************************************************
   // control registers
   // ************************************************************************
   // result registers have no write path at all
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         start_q   <= 1'b0;
         conv_en_q <= 1'b0;
         align_q   <= 1'b0;
         chan_q    <= 4'h0;
      end else if (wr_en && hit_start) begin
         start_q   <= wb[START_BIT];
         conv_en_q <= wb[EN_BIT];
         align_q   <= wb[ALIGN_BIT];
         chan_q    <= wb[3:0];
      end
   end

   // the forbidden source code is refused and the old source kept
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         src_q     <= 3'h0;
         ref_q     <= 2'h0;
         clk_sel_q <= 3'h0;
      end else if (wr_en && hit_src) begin
         if (wb[SRC_MSB:SRC_LSB] != SRC_FORBID) begin
            src_q <= wb[SRC_MSB:SRC_LSB];
         end
         ref_q     <= wb[REF_MSB:REF_LSB];
         clk_sel_q <= wb[2:0];
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         lowcur_q <= 1'b0;
         fixed1_q <= FIXED1_RESET;
         temp_sensor_enable_q   <= 1'b0;
         bg_en_q  <= 1'b0;
      end else begin
         if (wr_en && hit_mode) begin
            lowcur_q <= wb[LOWCUR_BIT];
            fixed1_q <= wb[FIXED1_BIT];
            temp_sensor_enable_q   <= wb[0];
         end
         if (wr_en && hit_bg) begin
            bg_en_q <= wb[0];
         end
      end
   end

   // software runs the trim search; the block just holds mode and trim code
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         amp_en_q   <= 1'b0;
         amp_bw_q   <= 2'h0;
         cal_mode_q <= 1'b0;
         cal_ref_q  <= 1'b0;
         trim_q     <= TRIM_RESET;
      end else begin
         if (wr_en && hit_amp) begin
            amp_en_q <= wb[AMP_EN_BIT];
            amp_bw_q <= wb[1:0];
         end
         if (wr_en && hit_cal) begin
            cal_mode_q <= wb[CALMODE_BIT];
            cal_ref_q  <= wb[CALREF_BIT];
            trim_q     <= wb[5:0];
         end
      end
   end

   // ************************************************************************
   // conversion sequencer
   // ************************************************************************
   // launch on the write that returns start low; needs the converter enabled
   assign launch    = wr_en && hit_start && start_q && !wb[START_BIT]
                      && wb[EN_BIT] && (state_q == CONV_IDLE);
   assign done_rise = done_s && !done_prev_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CONV_IDLE: begin
            if (launch) begin
               state_d = CONV_BUSY;
            end
         end
         CONV_BUSY: begin
            if (done_rise || !conv_en_q) begin
               state_d = CONV_IDLE;
            end
         end
      endcase
   end

   // result only moves at completion while enabled
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         state_q       <= CONV_IDLE;
         start_pulse_q <= 1'b0;
         done_prev_q   <= 1'b0;
         result_q      <= '0;
      end else begin
         state_q       <= state_d;
         start_pulse_q <= launch;
         done_prev_q   <= done_s;
         if (busy && done_rise && conv_en_q) begin
            result_q <= data_s;
         end
      end
   end

   // ************************************************************************
   // analog selection and outputs
   // ************************************************************************
   // one code goes to the single converter mux; undefined channels select nothing
   assign ANALOG_SEL_O = (src_q == SRC_BANDGAP) ? SEL_BANDGAP :
                         (src_q == SRC_TEMP)    ? SEL_TEMP :
                         (src_q == SRC_AMP_OUT) ? SEL_AMP_OUT :
                         (src_q == SRC_AMP_POS) ? SEL_AMP_POS :
                         chan_q[3]              ? SEL_NONE :
                         chan_q;

   result_format u_fmt (
      .align_i  (align_q),
      .result_i (result_q),
      .high_o   (fmt_high),
      .low_o    (fmt_low)
   );

   assign AMP_ENABLE_O      = amp_en_q;
   assign AMP_BW_O          = amp_bw_q;
   assign OFFSET_CAL_MODE_O = cal_mode_q;
   assign OFFSET_REF_SEL_O  = cal_ref_q;
   assign OFFSET_TRIM_O     = trim_q;
   assign CONV_ENABLE_O     = conv_en_q;
   assign CONV_START_O      = start_pulse_q;
   assign REF_SEL_O         = ref_q;
   assign CONV_CLK_SEL_O    = clk_sel_q;
   assign LOW_CURRENT_O     = lowcur_q;
   assign TEMP_SENSOR_EN_O  = temp_sensor_enable_q;
   assign BANDGAP_EN_O      = bg_en_q;

   // ************************************************************************
   // assertions
   // ************************************************************************
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);

   a_launch_busy: assert property (launch |=> busy && CONV_START_O ##1 !CONV_START_O)
      else $error("launch did not raise busy and a single start pulse");

   a_done_clears: assert property (busy && done_rise |=> !busy)
      else $error("busy not cleared after completion");

   a_result_capture: assert property (busy && done_rise && conv_en_q |=>
      result_q == $past(data_s))
      else $error("result not captured at completion");

   a_disabled_hold: assert property (!conv_en_q |=> $stable(result_q))
      else $error("result changed while converter disabled");

   a_result_readonly: assert property (wr_en && (hit_low || hit_high) && !busy
      |=> $stable(result_q))
      else $error("write altered result");

   a_status_zero: assert property (setup_ph && !PWRITE_I && hit_amp && !cal_mode_q |=>
      !PRDATA_O[AMP_STS_BIT])
      else $error("amplifier status visible outside calibration");

   a_cal_mode_write: assert property (wr_en && hit_cal |=>
      cal_mode_q == $past(PWDATA_I[CALMODE_BIT]) && trim_q == $past(PWDATA_I[5:0]))
      else $error("calibration mode or trim not updated");

   a_internal_sel: assert property (src_q == SRC_TEMP |-> ANALOG_SEL_O == SEL_TEMP)
      else $error("temperature source not selected");

   a_align_zero: assert property (!align_q |-> fmt_low[3:0] == 4'h0
      && fmt_high == result_q[11:4])
      else $error("left layout wrong");

   a_no_relaunch: assert property (busy && !done_rise && conv_en_q |=>
      busy && !CONV_START_O)
      else $error("second conversion launched while busy");
endmodule

/* testbench/afe_analog_model.sv */
// behavioural analog front end: offset comparator and single shared converter
`timescale 1ns/1ps
module afe_analog_model #(
   parameter logic [5:0] THRESH = 6'h17,
   parameter int         LAT    = 10
) (
   input  wire logic        clk_i,
   input  wire logic        conv_en_i,
   input  wire logic        conv_start_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        cal_mode_i,
   input  wire logic [5:0]  trim_i,
   output logic             status_o,
   output logic             done_o,
   output logic      [11:0] data_o
);
   logic [3:0] sel_q;
   logic [3:0] num_q;
   int         cnt_q;
   initial {status_o, done_o, data_o, sel_q, num_q, cnt_q} = '0;
   // outside calibration the comparator toggles every cycle, which sync3 never passes, so the synchronised status holds
   always @(posedge clk_i) begin
      status_o <= cal_mode_i ? (trim_i >= THRESH) : ~status_o;
      if (conv_start_i && conv_en_i) begin
         sel_q  <= sel_i;
         num_q  <= num_q + 4'h1;
         done_o <= 1'b0;
         data_o <= ~data_o;  // not valid until late in the conversion
         cnt_q  <= LAT;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end
      if (cnt_q == 3) data_o <= {sel_q, num_q, 4'h5};
      if (cnt_q == 1) done_o <= 1'b1;
   end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the offset trim and converter control block
`timescale 1ns/1ps
module tb_top;
   import afe_adc_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, hi_e, lo_e;
   logic [31:0] pwdata, prdata, rv;
   logic        amp_status, amp_en, cal_mode, cal_ref, conv_done, conv_en, conv_start;
   logic        lowcur, temp_sensor_enable, bgen, err, s, prev;
   logic [1:0]  amp_bw, ref_sel;
   logic [2:0]  clk_sel;
   logic [3:0]  asel, num, es;
   logic [5:0]  trim, up, dn;
   logic [11:0] conv_data, d;
   int          errors, n_checks, c, k;
   localparam logic [5:0] THRESH = 6'h17;
   localparam logic [7:0] RSTV[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h20};

   afe_adc_ctrl u_dut (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .AMP_STATUS_I(amp_status),
      .AMP_ENABLE_O(amp_en), .AMP_BW_O(amp_bw), .OFFSET_CAL_MODE_O(cal_mode),
      .OFFSET_REF_SEL_O(cal_ref), .OFFSET_TRIM_O(trim), .CONV_DONE_I(conv_done),
      .CONV_DATA_I(conv_data), .CONV_ENABLE_O(conv_en), .CONV_START_O(conv_start),
      .ANALOG_SEL_O(asel), .REF_SEL_O(ref_sel), .CONV_CLK_SEL_O(clk_sel),
      .LOW_CURRENT_O(lowcur), .TEMP_SENSOR_EN_O(temp_sensor_enable), .BANDGAP_EN_O(bgen));

   afe_analog_model #(.THRESH(THRESH), .LAT(10)) u_model (.clk_i(clk), .conv_en_i(conv_en),
      .conv_start_i(conv_start), .sel_i(asel), .cal_mode_i(cal_mode), .trim_i(trim),
      .status_o(amp_status), .done_o(conv_done), .data_o(conv_data));

   // ************************************************************************
   // bus tasks and comparison
   // ************************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // each transfer starts just after an edge and leaves one idle cycle behind it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rv  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      apb(1'b1, a, wd);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rv, {24'h0, exp});
   endtask

   // set a trim code, let the status cross the synchroniser, then read it
   task automatic trial(input logic [5:0] code, output logic st);
      wr(OFF_OFFSET_CAL, {2'b10, code});
      repeat (8) @(posedge clk);
      apb(1'b0, OFF_AMP_CTRL, 8'h00);
      st = rv[AMP_STS_BIT];
   endtask

   task automatic conv(input logic [2:0] src, input logic [3:0] ch, input logic al);
      wr(OFF_CTRL_SRC, {src, 5'h00});
      wr(OFF_CTRL_START, {3'b101, al, ch});
      wr(OFF_CTRL_START, {3'b001, al, ch});
      num++;
      es = (src >= 3'h1 && src <= 3'h4) ? 4'h7 + {1'b0, src} : ch;
      chk(32'(asel), 32'(es));
      apb(1'b0, OFF_CTRL_START, 8'h00);
      chk(32'(rv[BUSY_BIT]), 32'h1);
      for (k = 0; k < 40 && rv[BUSY_BIT] !== 1'b0; k++) apb(1'b0, OFF_CTRL_START, 8'h00);
      chk(32'(rv[BUSY_BIT]), 32'h0);
      d    = {es, num, 4'h5};
      hi_e = al ? {4'h0, d[11:8]} : d[11:4];
      lo_e = al ? d[7:0] : {d[3:0], 4'h0};
      rchk(OFF_RES_HIGH, hi_e);
      rchk(OFF_RES_LOW, lo_e);
   endtask

   task automatic results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ************************************************************************
   // clock, reset, watchdog and tests
   // ************************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // the whole sequence needs well under two thousand cycles; this is a generous margin
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      results();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, num, errors, n_checks} = '0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      for (c = 0; c < 8; c++) rchk(8'(c * 4), RSTV[c]);
      apb(1'b0, 8'h20, 8'h00);
      chk(rv, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset and map done");
      wr(OFF_AMP_CTRL, 8'h40);
      rchk(OFF_AMP_CTRL, 8'h40);
      chk(32'({amp_en, amp_bw}), 32'h4);
      trial(6'h00, prev);
      chk(32'({cal_mode, cal_ref}), 32'h2);
      for (c = 1; c < 63; c++) begin
         trial(6'(c), s);
         if (s !== prev) break;
      end
      up = 6'(c);
      chk(32'(up), 32'(THRESH));
      trial(6'h3f, prev);
      for (c = 62; c > 0; c--) begin
         trial(6'(c), s);
         if (s !== prev) break;
      end
      dn = 6'(c);
      chk(32'(dn), 32'(THRESH - 6'h1));
      // leave the synchronised status high so a leak into normal mode would show
      trial(6'h3f, s);
      wr(OFF_OFFSET_CAL, {2'b00, 6'((7'(up) + 7'(dn)) >> 1)});
      chk(32'(trim), 32'h16);
      chk(32'(cal_mode), 32'h0);
      rchk(OFF_AMP_CTRL, 8'h40);
      $display("test offset calibration done");
      wr(OFF_BANDGAP, 8'h01);
      wr(OFF_CTRL_MODE, 8'h03);
      chk(32'({lowcur, bgen, temp_sensor_enable}), 32'h3);
      for (c = 0; c < 7; c++) conv(3'(c), (c >= 1 && c <= 4) ? 4'(8 + c) : 4'(c), c[0]);
      $display("test conversions done");
      wr(OFF_CTRL_SRC, 8'hff);
      rchk(OFF_CTRL_SRC, 8'hdf);
      chk(32'({ref_sel, clk_sel}), 32'h1f);
      wr(OFF_RES_LOW, 8'hff);
      wr(OFF_RES_HIGH, 8'hff);
      rchk(OFF_RES_HIGH, hi_e);
      rchk(OFF_RES_LOW, lo_e);
      // abort a running conversion by disabling: its late completion must not land
      wr(OFF_CTRL_START, 8'ha0);
      wr(OFF_CTRL_START, 8'h20);
      rchk(OFF_CTRL_START, 8'h60);
      wr(OFF_CTRL_START, 8'h00);
      rchk(OFF_CTRL_START, 8'h00);
      wr(OFF_CTRL_START, 8'h80);
      wr(OFF_CTRL_START, 8'h00);
      repeat (20) @(posedge clk);
      rchk(OFF_CTRL_START, 8'h00);
      rchk(OFF_RES_HIGH, hi_e);
      rchk(OFF_RES_LOW, lo_e);
      wr(OFF_CTRL_SRC, 8'h00);
      wr(OFF_CTRL_START, 8'h09);
      chk(32'(asel), 32'(SEL_NONE));
      $display("test refusals and disable done");
      results();
   end
endmodule
